// [rtl/pmw_pkg.sv]
package pmw_pkg;

  // ==========================================================
  // Control register, reached by model-specific index
  localparam logic [31:0] PMW_CTRL_INDEX = 32'hC000_0086;
  localparam int PMW_CTRL_WIDTH = 64;
  localparam logic [63:0] PMW_CTRL_RESET = 64'h0000_0000_0000_0000;
  // Writable bits: base 15:4, special-cycle bit 1, enable bit 0
  localparam logic [63:0] PMW_CTRL_WMASK = 64'h0000_0000_0000_FFF3;
  localparam int PMW_EN_BIT = 0;
  localparam int PMW_SPEC_BIT = 1;
  localparam int PMW_BASE_LSB = 4;
  localparam int PMW_BASE_MSB = 15;

  // ==========================================================
  // Window layout: four dwords, only dword 2 (bytes 11-8) is stored
  localparam logic [1:0] PMW_RATIO_DWORD = 2'h2;
  localparam logic [31:0] PMW_RATIO_RESET = 32'h0000_000A;
  localparam logic [4:0] PMW_VCODE_RESET = 5'h0A;
  localparam logic [3:0] PMW_FULL_LANES = 4'hF;

  // ==========================================================
  // Special bus cycle encoding
  localparam logic [7:0] PMW_SC_LANES_N = 8'hBF;
  localparam logic [7:0] PMW_IDLE_LANES_N = 8'hFF;
  localparam logic [28:0] PMW_SC_ADDR = 29'h0000_0000;

  typedef enum logic [1:0]
  {
    PMW_SC_IDLE = 2'b00,
    PMW_SC_ADDR_PH = 2'b01,
    PMW_SC_WAIT = 2'b10
  } pmw_sc_state_type;

endpackage

// [rtl/pmw_special_cycle.sv]
`timescale 1ns/1ps
module pmw_special_cycle
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic scStart,
  input wire logic burstReadyN,
  output logic scIdle,
  output logic addrStrobeN,
  output logic [7:0] byteLaneStrobesN,
  output logic [28:0] busAddr,
  output logic dataCodeSel,
  output logic memIoSel,
  output logic writeReadSel,
  output logic busCycleActive
);
  import pmw_pkg::*;

  pmw_sc_state_type state_r;
  pmw_sc_state_type state_nxt;

  // ==========================================================
  // Sequencer: address phase, then wait for the far end's ready
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      PMW_SC_IDLE:
      begin
        if (scStart)
          state_nxt = PMW_SC_ADDR_PH;
      end
      PMW_SC_ADDR_PH:
        state_nxt = PMW_SC_WAIT;
      PMW_SC_WAIT:
      begin
        // Only the far end ends the cycle; no time-out here, see RL9
        if (!burstReadyN)
          state_nxt = PMW_SC_IDLE;
      end
      default:
        state_nxt = PMW_SC_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      state_r <= PMW_SC_IDLE;
    else
      state_r <= state_nxt;
  end

  // Bus pins are flops so they never glitch toward the chipset
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      scIdle <= 1'b1;
      addrStrobeN <= 1'b1;
      byteLaneStrobesN <= PMW_IDLE_LANES_N;
      busAddr <= '0;
      dataCodeSel <= 1'b0;
      memIoSel <= 1'b0;
      writeReadSel <= 1'b0;
      busCycleActive <= 1'b0;
    end
    else
    begin
      scIdle <= (state_nxt == PMW_SC_IDLE);
      addrStrobeN <= !(state_nxt == PMW_SC_ADDR_PH);
      busCycleActive <= (state_nxt != PMW_SC_IDLE);
      if (state_nxt != PMW_SC_IDLE)
      begin
        byteLaneStrobesN <= PMW_SC_LANES_N; // see RL7
        busAddr <= PMW_SC_ADDR; // see RL8
        dataCodeSel <= 1'b0; // see RL8
        memIoSel <= 1'b0; // see RL8
        writeReadSel <= 1'b1; // see RL8
      end
      else
      begin
        byteLaneStrobesN <= PMW_IDLE_LANES_N;
        busAddr <= '0;
        dataCodeSel <= 1'b0;
        memIoSel <= 1'b0;
        writeReadSel <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Checks
  sequence s_start_taken;
    scIdle && scStart;
  endsequence

  sequence s_addr_phase;
    !addrStrobeN && byteLaneStrobesN == 8'hBF && busAddr == 29'h0 && !dataCodeSel
      && !memIoSel && writeReadSel;
  endsequence

  a_special_encoding: assert property (@(posedge ref_clk) disable iff (!reset_n) // see RL8
    s_start_taken |=> s_addr_phase ##1 (addrStrobeN && byteLaneStrobesN == 8'hBF))
    else $error("special cycle encoding wrong");

  a_special_holds: assert property (@(posedge ref_clk) disable iff (!reset_n) // see RL9
    (state_r == PMW_SC_WAIT && burstReadyN) |=> (busCycleActive && !scIdle))
    else $error("special cycle dropped before ready");

  a_special_ends: assert property (@(posedge ref_clk) disable iff (!reset_n) // see RL9
    (state_r == PMW_SC_WAIT && !burstReadyN) |=> (scIdle && byteLaneStrobesN == 8'hFF))
    else $error("special cycle not ended on ready");

endmodule

// [rtl/pmw_window_decoder.sv]
`timescale 1ns/1ps
// How it works
// RL1: Base field in control bits 15:4
// RL2: Window software uses aligned dword accesses only
// RL3: Window hits are claimed, no host cycle
// RL4: Partial or misaligned window accesses go out
// RL5: Reset clears window, voltage code 01010b
// RL6: Control resets zero; reserved bits read zero
// RL7: Special-cycle bit adds cycle, lanes BFh
// RL8: Special cycle: D/C low, M/IO low, W/R high
// RL9: System logic ends special cycles with ready
// RL10: Enable gates decode, window contents kept
// RL11: Disabled window: all accesses go out
// RL12: Software enables window only while using it
// RL13: Software reprograms everything after each reset
// RL14: Control register at model index C000_0086h
// RL15: Bytes 11-8 stored; others read zero
// RL16: Hit needs enable, base match, full dword
module pmw_window_decoder
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic msrWrEn,
  input wire logic msrRdEn,
  input wire logic [31:0] msrIndex,
  input wire logic [pmw_pkg::PMW_CTRL_WIDTH-1:0] msrWrData,
  output logic [pmw_pkg::PMW_CTRL_WIDTH-1:0] msrRdData,
  output logic msrAck,
  output logic msrFault,
  input wire logic ioReq,
  input wire logic ioWrite,
  input wire logic [15:0] ioAddr,
  input wire logic [3:0] ioByteEn,
  input wire logic [31:0] ioWrData,
  output logic ioReady,
  output logic ioClaim,
  output logic ioForward,
  output logic [31:0] ioRdData,
  output logic [31:0] ratioVoltageField,
  output logic [4:0] voltageCodeOutput,
  input wire logic burstReadyN,
  output logic addrStrobeN,
  output logic [7:0] byteLaneStrobesN,
  output logic [28:0] busAddr,
  output logic dataCodeSel,
  output logic memIoSel,
  output logic writeReadSel,
  output logic busCycleActive
);
  import pmw_pkg::*;

  logic [63:0] ctrl_r;
  logic [31:0] ratio_r;
  logic [1:0] claimDword_r;
  logic scIdle;
  logic msrSel;
  logic ioTaken;
  logic baseMatch;
  logic aligned;
  logic windowHit;
  logic scStart;

  // ==========================================================
  // Decode of model-specific accesses and I/O requests
  assign msrSel = (msrIndex == PMW_CTRL_INDEX); // see RL14
  // A request is only taken while the special-cycle path can accept one
  // Limitation: nothing is queued, the core must hold off while ready is low
  assign ioTaken = ioReq && ioReady;
  assign baseMatch = (ioAddr[15:4] == ctrl_r[PMW_BASE_MSB:PMW_BASE_LSB]); // see RL1
  // Anything but a full aligned dword is not ours to claim, see RL2
  assign aligned = (ioAddr[1:0] == 2'b00) && (ioByteEn == PMW_FULL_LANES); // see RL16
  assign windowHit = ioTaken && ctrl_r[PMW_EN_BIT] && baseMatch && aligned; // see RL16
  assign scStart = windowHit && ctrl_r[PMW_SPEC_BIT]; // see RL7

  // ==========================================================
  // Control register: only the mapped bits store, the rest stay zero
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      ctrl_r <= PMW_CTRL_RESET; // see RL6
    else if (msrWrEn && msrSel)
      ctrl_r <= msrWrData & PMW_CTRL_WMASK; // see RL14
  end

  // Read data and acknowledge, one cycle after the access
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      msrRdData <= '0;
      msrAck <= 1'b0;
      msrFault <= 1'b0;
    end
    else
    begin
      msrAck <= (msrWrEn || msrRdEn) && msrSel;
      msrFault <= (msrWrEn || msrRdEn) && !msrSel;
      if (msrRdEn && msrSel)
        msrRdData <= ctrl_r & PMW_CTRL_WMASK; // see RL6
      else
        msrRdData <= '0;
    end
  end

  // ==========================================================
  // Window storage; clearing the enable never touches it
  // Write-only count bits read back as written; nothing here acts on them
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      ratio_r <= PMW_RATIO_RESET; // see RL5
    else if (windowHit && ioWrite && ioAddr[3:2] == PMW_RATIO_DWORD)
      ratio_r <= ioWrData; // see RL10
  end

  // Pins mirror the stored field; they carry the reset code from reset on
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ratioVoltageField <= PMW_RATIO_RESET;
      voltageCodeOutput <= PMW_VCODE_RESET; // see RL5
    end
    else
    begin
      ratioVoltageField <= ratio_r;
      voltageCodeOutput <= ratio_r[4:0];
    end
  end

  // ==========================================================
  // Answers to the core: claimed internally or sent to the host bus
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ioClaim <= 1'b0;
      ioForward <= 1'b0;
      ioRdData <= '0;
      claimDword_r <= 2'b00;
    end
    else
    begin
      ioClaim <= windowHit; // see RL3
      // Misses, partial lanes and a disabled window all go out, see RL4
      ioForward <= ioTaken && !windowHit; // see RL11
      claimDword_r <= ioAddr[3:2];
      if (windowHit && !ioWrite && ioAddr[3:2] == PMW_RATIO_DWORD)
        ioRdData <= ratio_r; // see RL15
      else
        ioRdData <= '0; // see RL15
    end
  end

  // Ready is held low while a special cycle is outstanding
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      ioReady <= 1'b1;
    else
      ioReady <= scIdle && !scStart;
  end

  // ==========================================================
  // Special bus cycle sequencer
  pmw_special_cycle u_special
  (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .scStart(scStart),
    .burstReadyN(burstReadyN),
    .scIdle(scIdle),
    .addrStrobeN(addrStrobeN),
    .byteLaneStrobesN(byteLaneStrobesN),
    .busAddr(busAddr),
    .dataCodeSel(dataCodeSel),
    .memIoSel(memIoSel),
    .writeReadSel(writeReadSel),
    .busCycleActive(busCycleActive)
  );

  // ==========================================================
  // Checks
  sequence s_full_hit;
    ioReq && ioReady && ctrl_r[0] && ioAddr[15:4] == ctrl_r[15:4]
      && ioAddr[1:0] == 2'b00 && ioByteEn == 4'hF;
  endsequence

  sequence s_partial_in_window;
    ioReq && ioReady && ctrl_r[0] && ioAddr[15:4] == ctrl_r[15:4]
      && (ioAddr[1:0] != 2'b00 || ioByteEn != 4'hF);
  endsequence

  a_hit_claims: assert property (@(posedge ref_clk) disable iff (!reset_n) // see RL3
    s_full_hit |=> (ioClaim && !ioForward))
    else $error("window hit not claimed");

  a_partial_forwards: assert property (@(posedge ref_clk) disable iff (!reset_n) // see RL4
    s_partial_in_window |=> (ioForward && !ioClaim))
    else $error("partial window access was claimed");

  a_disabled_forwards: assert property (@(posedge ref_clk) disable iff (!reset_n) // see RL11
    (ioReq && ioReady && !ctrl_r[0]) |=> (ioForward && !ioClaim))
    else $error("disabled window access claimed");

  a_reserved_zero: assert property (@(posedge ref_clk) disable iff (!reset_n) // see RL6
    msrAck |-> (msrRdData[63:16] == 48'h0 && msrRdData[3:2] == 2'b00))
    else $error("reserved control bits read nonzero");

  a_ctrl_write: assert property (@(posedge ref_clk) disable iff (!reset_n) // see RL14
    (msrWrEn && msrIndex == 32'hC000_0086)
      |=> (ctrl_r[15:0] == ($past(msrWrData[15:0]) & 16'hFFF3)))
    else $error("control write not stored");

  a_disable_keeps: assert property (@(posedge ref_clk) disable iff (!reset_n) // see RL10
    !ctrl_r[0] |=> $stable(ratio_r))
    else $error("window changed while disabled");

  a_reset_values: assert property (@(posedge ref_clk) disable iff (!reset_n) // see RL5
    $rose(reset_n) |-> (voltageCodeOutput == 5'h0A && ctrl_r == 64'h0 && !ioClaim))
    else $error("reset values wrong");

  a_reserved_window: assert property (@(posedge ref_clk) disable iff (!reset_n) // see RL15
    (ioClaim && claimDword_r != 2'h2) |-> ioRdData == 32'h0)
    else $error("reserved window dword read nonzero");

  a_special_start: assert property (@(posedge ref_clk) disable iff (!reset_n) // see RL7
    (s_full_hit ##0 ctrl_r[1]) |=> (!addrStrobeN && byteLaneStrobesN == 8'hBF && !ioReady))
    else $error("special cycle not started on hit");

  a_no_special_off: assert property (@(posedge ref_clk) disable iff (!reset_n) // see RL7
    (s_full_hit ##0 !ctrl_r[1] ##0 scIdle) |=> addrStrobeN)
    else $error("special cycle without request bit");

  a_lane_idle: assert property (@(posedge ref_clk) disable iff (!reset_n) // see RL7
    !busCycleActive |-> (byteLaneStrobesN == 8'hFF && addrStrobeN))
    else $error("bus lines active outside special cycle");

  // ==========================================================
  // Register port checks; a wrong index must leave no trace
  sequence s_ctrl_access;
    (msrWrEn || msrRdEn) && msrIndex == PMW_CTRL_INDEX;
  endsequence

  sequence s_other_access;
    (msrWrEn || msrRdEn) && msrIndex != PMW_CTRL_INDEX;
  endsequence

  a_ctrl_ack: assert property (@(posedge ref_clk) disable iff (!reset_n) // see RL14
    s_ctrl_access |=> (msrAck && !msrFault))
    else $error("control access not acknowledged");

  a_other_fault: assert property (@(posedge ref_clk) disable iff (!reset_n) // see RL14
    s_other_access |=> (msrFault && !msrAck && msrRdData == 64'h0))
    else $error("foreign index not faulted");

  a_other_no_write: assert property (@(posedge ref_clk) disable iff (!reset_n) // see RL14
    (msrWrEn && msrIndex != PMW_CTRL_INDEX) |=> $stable(ctrl_r))
    else $error("foreign index changed control");

  a_read_back: assert property (@(posedge ref_clk) disable iff (!reset_n) // see RL6
    (msrRdEn && msrIndex == PMW_CTRL_INDEX) |=> (msrRdData == $past(ctrl_r)))
    else $error("control read back wrong");

  a_reserved_store: assert property (@(posedge ref_clk) disable iff (!reset_n) // see RL6
    (ctrl_r[63:16] == 48'h0 && ctrl_r[3:2] == 2'h0))
    else $error("reserved control bits stored");

  // ==========================================================
  // Window data checks; refused requests must leave no trace
  sequence s_field_write;
    windowHit && ioWrite && ioAddr[3:2] == 2'h2;
  endsequence

  a_field_write: assert property (@(posedge ref_clk) disable iff (!reset_n) // see RL15
    s_field_write |=> (ratio_r == $past(ioWrData)))
    else $error("field write lost");

  a_reserved_write: assert property (@(posedge ref_clk) disable iff (!reset_n) // see RL15
    (windowHit && ioWrite && ioAddr[3:2] != 2'h2) |=> $stable(ratio_r))
    else $error("reserved window dword stored");

  a_io_data_clear: assert property (@(posedge ref_clk) disable iff (!reset_n) // see RL15
    !ioClaim |-> (ioRdData == 32'h0))
    else $error("read data outside a claim");

  a_refused_silent: assert property (@(posedge ref_clk) disable iff (!reset_n) // see RL7
    (ioReq && !ioReady) |=> (!ioClaim && !ioForward))
    else $error("request taken while not ready");

  a_one_answer: assert property (@(posedge ref_clk) disable iff (!reset_n) // see RL3
    !(ioClaim && ioForward))
    else $error("request both claimed and forwarded");

  a_busy_not_ready: assert property (@(posedge ref_clk) disable iff (!reset_n) // see RL7
    busCycleActive |-> !ioReady)
    else $error("ready raised during special cycle");

  a_base_miss: assert property (@(posedge ref_clk) disable iff (!reset_n) // see RL1
    (ioReq && ioReady && ioAddr[15:4] != ctrl_r[15:4]) |=> (ioForward && !ioClaim))
    else $error("access outside window claimed");

  a_pins_follow: assert property (@(posedge ref_clk) disable iff (!reset_n) // see RL5
    voltageCodeOutput == ratioVoltageField[4:0])
    else $error("voltage code pins disagree with field");

endmodule

// [sim/pmw_sys_logic_model.sv]
`timescale 1ns/1ps
// =====
// System logic: ends every special cycle with one ready pulse
module pmw_sys_logic_model
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic addrStrobeN,
  input wire logic [3:0] waitCycles,
  output logic burstReadyN
);
  logic [3:0] cnt_r;

  // Ready idles high; a slow answer inserts waitCycles wait states
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt_r <= 4'h0;
      burstReadyN <= 1'b1;
    end
    else if (!addrStrobeN)
    begin
      cnt_r <= waitCycles;
      burstReadyN <= (waitCycles != 4'h0);
    end
    else
    begin
      cnt_r <= (cnt_r != 4'h0) ? cnt_r - 4'h1 : 4'h0;
      burstReadyN <= (cnt_r != 4'h1);
    end
  end
endmodule

// [sim/testbench.sv]
`timescale 1ns/1ps
module testbench;
  import pmw_pkg::*;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic msrWrEn = 1'b0;
  logic msrRdEn = 1'b0;
  logic [31:0] msrIndex = 32'h0;
  logic [63:0] msrWrData = 64'h0;
  logic ioReq = 1'b0;
  logic ioWrite = 1'b0;
  logic [15:0] ioAddr = 16'h0;
  logic [3:0] ioByteEn = 4'h0;
  logic [31:0] ioWrData = 32'h0;
  logic [3:0] waitCycles = 4'h0;
  logic burstReadyN, msrAck, msrFault, ioReady, ioClaim, ioForward;
  logic addrStrobeN, dataCodeSel, memIoSel, writeReadSel, busCycleActive;
  logic [63:0] msrRdData;
  logic [31:0] ioRdData, ratioVoltageField;
  logic [4:0] voltageCodeOutput;
  logic [7:0] byteLaneStrobesN;
  logic [28:0] busAddr;
  int numErrors = 0;
  int numChecks = 0;
  int n;
  logic [19:0] fwd [6] = '{20'h1239F, 20'h123AF, 20'h12383, 20'h1238E, 20'h1248F, 20'h1228F};

  pmw_window_decoder DUT (.ref_clk(ref_clk), .reset_n(reset_n), .msrWrEn(msrWrEn),
    .msrRdEn(msrRdEn), .msrIndex(msrIndex), .msrWrData(msrWrData), .msrRdData(msrRdData),
    .msrAck(msrAck), .msrFault(msrFault), .ioReq(ioReq), .ioWrite(ioWrite), .ioAddr(ioAddr),
    .ioByteEn(ioByteEn), .ioWrData(ioWrData), .ioReady(ioReady), .ioClaim(ioClaim),
    .ioForward(ioForward), .ioRdData(ioRdData), .ratioVoltageField(ratioVoltageField),
    .voltageCodeOutput(voltageCodeOutput), .burstReadyN(burstReadyN),
    .addrStrobeN(addrStrobeN), .byteLaneStrobesN(byteLaneStrobesN), .busAddr(busAddr),
    .dataCodeSel(dataCodeSel), .memIoSel(memIoSel), .writeReadSel(writeReadSel),
    .busCycleActive(busCycleActive));

  pmw_sys_logic_model sysLogic (.ref_clk(ref_clk), .reset_n(reset_n),
    .addrStrobeN(addrStrobeN), .waitCycles(waitCycles), .burstReadyN(burstReadyN));

  // 50 MHz clock
  always #10 ref_clk = ~ref_clk;

  // =====
  // Shared tasks; all start and end at a falling edge
  task automatic wrapUp;
    $display("checks %0d errors %0d", numChecks, numErrors);
    if (numErrors == 0 && numChecks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    numChecks++;
    if (got !== exp)
    begin
      numErrors++;
      $display("unexpected at %0t: %s got %0h want %0h", $time, what, got, exp);
    end
  endtask

  // One strobe cycle; the answer stands only in the cycle after the taking edge
  task automatic msr(input logic wr, input logic [31:0] idx, input logic [63:0] d,
    input logic ok, input logic [63:0] rd);
    @(negedge ref_clk);
    msrWrEn = wr;
    msrRdEn = !wr;
    msrIndex = idx;
    msrWrData = d;
    @(negedge ref_clk);
    msrWrEn = 1'b0;
    msrRdEn = 1'b0;
    chk({msrAck, msrFault}, {ok, !ok}, "msr answer");
    if (!wr)
      chk(msrRdData, ok ? rd : 64'h0, "msr data");
  endtask

  // Waits for ready under a bound, since a special cycle holds it low
  task automatic io(input logic wr, input logic [15:0] a, input logic [3:0] be,
    input logic [31:0] d, input logic claim, input logic [31:0] rd);
    @(negedge ref_clk);
    for (int i = 0; i < 20 && ioReady !== 1'b1; i++)
      @(negedge ref_clk);
    if (ioReady !== 1'b1)
    begin
      numErrors++;
      $display("unexpected at %0t: ready timeout", $time);
      wrapUp();
    end
    ioReq = 1'b1;
    ioWrite = wr;
    ioAddr = a;
    ioByteEn = be;
    ioWrData = d;
    @(negedge ref_clk);
    ioReq = 1'b0;
    chk({ioClaim, ioForward}, {claim, !claim}, "io answer");
    if (claim && !wr)
      chk(ioRdData, rd, "io data");
  endtask

  // =====
  // Test sequence
  initial
  begin
    repeat (3) @(negedge ref_clk);
    reset_n = 1'b1;
    chk({ratioVoltageField, voltageCodeOutput}, {32'h0000_000A, 5'h0A}, "rst field");
    chk({addrStrobeN, byteLaneStrobesN, writeReadSel, ioReady}, 11'h7FD, "rst bus");
    msr(1'b0, PMW_CTRL_INDEX, 64'h0, 1'b1, 64'h0);
    $display("test reset done");
    msr(1'b1, PMW_CTRL_INDEX, '1, 1'b1, 64'h0);
    msr(1'b0, PMW_CTRL_INDEX, 64'h0, 1'b1, 64'h0000_0000_0000_FFF3);
    msr(1'b1, 32'hC000_0087, 64'h0, 1'b0, 64'h0);
    msr(1'b0, 32'hC000_0085, 64'h0, 1'b0, 64'h0);
    msr(1'b0, PMW_CTRL_INDEX, 64'h0, 1'b1, 64'h0000_0000_0000_FFF3);
    $display("test control done");
    msr(1'b1, PMW_CTRL_INDEX, 64'h1231, 1'b1, 64'h0);
    io(1'b1, 16'h1238, 4'hF, 32'h8C3B_2E15, 1'b1, 32'h0);
    // The pins follow the stored field one cycle after the claim
    @(negedge ref_clk);
    chk({ratioVoltageField, voltageCodeOutput}, {32'h8C3B_2E15, 5'h15}, "field");
    io(1'b0, 16'h1238, 4'hF, 32'h0, 1'b1, 32'h8C3B_2E15);
    for (int k = 0; k < 4; k++)
    begin
      if (k != 2)
      begin
        io(1'b1, 16'h1230 + 16'(4 * k), 4'hF, 32'hFFFF_FFFF, 1'b1, 32'h0);
        io(1'b0, 16'h1230 + 16'(4 * k), 4'hF, 32'h0, 1'b1, 32'h0);
      end
    end
    foreach (fwd[k])
    begin
      io(1'b1, fwd[k][19:4], fwd[k][3:0], 32'h0, 1'b0, 32'h0);
      io(1'b0, fwd[k][19:4], fwd[k][3:0], 32'h0, 1'b0, 32'h0);
    end
    chk(ratioVoltageField, 32'h8C3B_2E15, "field kept");
    $display("test decode done");
    msr(1'b1, PMW_CTRL_INDEX, 64'h1230, 1'b1, 64'h0);
    io(1'b1, 16'h1238, 4'hF, 32'h0, 1'b0, 32'h0);
    io(1'b0, 16'h1238, 4'hF, 32'h0, 1'b0, 32'h0);
    msr(1'b1, PMW_CTRL_INDEX, 64'h1233, 1'b1, 64'h0);
    io(1'b0, 16'h1238, 4'hF, 32'h0, 1'b1, 32'h8C3B_2E15);
    $display("test enable done");
    // Prompt and slow termination; a request while not ready must vanish
    for (int w = 0; w < 4; w += 3)
    begin
      waitCycles = 4'(w);
      io(1'b0, 16'h1238, 4'hF, 32'h0, 1'b1, 32'h8C3B_2E15);
      chk({addrStrobeN, byteLaneStrobesN, busAddr, dataCodeSel, memIoSel, writeReadSel,
        busCycleActive, ioReady}, {1'b0, 8'hBF, 29'h0, 4'b0011, 1'b0}, "special");
      // Count the cycles in which the bus cycle stands, address phase included
      n = 0;
      for (int i = 0; i < 20 && busCycleActive === 1'b1; i++)
      begin
        n++;
        @(negedge ref_clk);
      end
      chk(64'(n), 64'(2 + w), "cycle length");
      chk({byteLaneStrobesN, writeReadSel, ioReady}, 10'h3FC, "bus idle");
      // Ready stays low one cycle past the bus end, so this write must vanish
      ioReq = 1'b1;
      ioWrite = 1'b1;
      @(negedge ref_clk);
      ioReq = 1'b0;
      chk({ioClaim, ioForward}, 2'b00, "refused");
    end
    chk(ratioVoltageField, 32'h8C3B_2E15, "field kept");
    msr(1'b1, PMW_CTRL_INDEX, 64'h1232, 1'b1, 64'h0);
    io(1'b0, 16'h1238, 4'hF, 32'h0, 1'b0, 32'h0);
    $display("test special done");
    reset_n = 1'b0;
    @(negedge ref_clk);
    chk({ratioVoltageField, voltageCodeOutput}, {32'h0000_000A, 5'h0A}, "rst field");
    reset_n = 1'b1;
    msr(1'b0, PMW_CTRL_INDEX, 64'h0, 1'b1, 64'h0);
    msr(1'b1, PMW_CTRL_INDEX, 64'h1231, 1'b1, 64'h0);
    io(1'b0, 16'h1238, 4'hF, 32'h0, 1'b1, 32'h0000_000A);
    $display("test second reset done");
    wrapUp();
  end
endmodule
